/* File: include/wide_timer_pkg.sv */
package wide_timer_pkg;
	// Register offsets, one byte-wide register per word
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFF_CTRL_A  = 6'h00;
	localparam logic [5:0] OFF_CTRL_B  = 6'h04;
	localparam logic [5:0] OFF_CTRL_C  = 6'h08;
	localparam logic [5:0] OFF_COUNT_L = 6'h0C;
	localparam logic [5:0] OFF_COUNT_H = 6'h10;
	localparam logic [5:0] OFF_CMPA_L  = 6'h14;
	localparam logic [5:0] OFF_CMPA_H  = 6'h18;
	localparam logic [5:0] OFF_CMPB_L  = 6'h1C;
	localparam logic [5:0] OFF_CMPB_H  = 6'h20;
	localparam logic [5:0] OFF_CAPT_L  = 6'h24;
	localparam logic [5:0] OFF_CAPT_H  = 6'h28;
	localparam logic [5:0] OFF_MASK    = 6'h2C;
	localparam logic [5:0] OFF_FLAG    = 6'h30;
	localparam logic [5:0] OFF_POWER   = 6'h34;
	// Field positions
	localparam int COMA_LSB   = 6;
	localparam int COMB_LSB   = 4;
	localparam int WGMLO_LSB  = 0;
	localparam int WGMHI_LSB  = 3;
	localparam int CS_LSB     = 0;
	localparam int NOISE_BIT  = 7;
	localparam int EDGE_BIT   = 6;
	localparam int FORCEA_BIT = 7;
	localparam int FORCEB_BIT = 6;
	localparam int SRC_BIT    = 0;
	localparam int FLG_OVF    = 0;
	localparam int FLG_CMPA   = 1;
	localparam int FLG_CMPB   = 2;
	localparam int FLG_CAPT   = 3;
	// Reset values and count limits
	localparam logic [7:0]  CTRL_RST    = 8'h00;
	localparam logic [15:0] BOTTOM_VAL  = 16'h0000;
	localparam logic [15:0] MAX_VAL     = 16'hFFFF;
	localparam logic [15:0] FIXED_TOP_8 = 16'h00FF;
	localparam logic [15:0] FIXED_TOP_9 = 16'h01FF;
	localparam logic [15:0] FIXED_TOP_A = 16'h03FF;
	// Clock select codes
	localparam logic [2:0] CS_STOP  = 3'h0;
	localparam logic [2:0] CS_DIV1  = 3'h1;
	localparam logic [2:0] CS_DIV8  = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1K = 3'h5;
	localparam logic [2:0] CS_EXTF  = 3'h6;
	localparam logic [2:0] CS_EXTR  = 3'h7;
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		SEQ_NORMAL = 2'b00,
		SEQ_CTC    = 2'b01,
		SEQ_FAST   = 2'b10,
		SEQ_PHASE  = 2'b11
	} seq_t;
	typedef enum logic [1:0] {
		TOPSRC_FIXED = 2'b00,
		TOPSRC_CMPA  = 2'b01,
		TOPSRC_CAPT  = 2'b10
	} topsrc_t;
endpackage

/* File: hdl/timer_tick_gen.sv */
`timescale 1ns/1ps
module timer_tick_gen
	import wide_timer_pkg::*;
(
	// Clock and reset
	input  logic       mclk,
	input  logic       reset,
	// Control
	input  logic [2:0] clockSel,
	input  logic       powerOff,
	input  logic       extPin,
	// Tick out
	output logic       tick
);
	logic [9:0] pre_q, pre_d;
	logic       extPrev_q, extPrev_d;
	logic       tick_q, tick_d;

	// Prescaler and edge select; stopped source gives no tick
	always_comb
	begin
		pre_d = powerOff ? 10'h000 : pre_q + 10'h001;
		extPrev_d = extPin;
		case (clockSel)
			CS_DIV1:   tick_d = 1'b1;
			CS_DIV8:   tick_d = &pre_q[2:0];
			CS_DIV64:  tick_d = &pre_q[5:0];
			CS_DIV256: tick_d = &pre_q[7:0];
			CS_DIV1K:  tick_d = &pre_q;
			CS_EXTF:   tick_d = extPrev_q & ~extPin;
			CS_EXTR:   tick_d = ~extPrev_q & extPin;
			default:   tick_d = 1'b0;
		endcase
		if (powerOff)
			tick_d = 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			pre_q <= 10'h000;
			extPrev_q <= 1'b0;
			tick_q <= 1'b0;
		end
		else
		begin
			pre_q <= pre_d;
			extPrev_q <= extPrev_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule

/* File: hdl/capture_filter.sv */
`timescale 1ns/1ps
module capture_filter
#(
	parameter int FILTER_LEN = 4
)
(
	// Clock and reset
	input  logic mclk,
	input  logic reset,
	// Source and options
	input  logic sampleIn,
	input  logic filterOn,
	input  logic risingSel,
	// Event out
	output logic edgeSeen
);
	if (FILTER_LEN < 2 || FILTER_LEN > 16)
	begin : gCheck
		$error("capture_filter: FILTER_LEN must be 2..16");
	end

	logic [FILTER_LEN-1:0] hist_q, hist_d;
	logic                  level_q, level_d;
	logic                  event_q, event_d;

	// With the filter on, the level moves only after a full run of equal samples; off, it follows the source
	always_comb
	begin
		hist_d = {hist_q[FILTER_LEN-2:0], sampleIn};
		level_d = level_q;
		if (!filterOn)
			level_d = sampleIn;
		else if (&hist_q)
			level_d = 1'b1;
		else if (~|hist_q)
			level_d = 1'b0;
		event_d = risingSel ? (level_d & ~level_q)
			: (~level_d & level_q);
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			hist_q <= '0;
			level_q <= 1'b0;
			event_q <= 1'b0;
		end
		else
		begin
			hist_q <= hist_d;
			level_q <= level_d;
			event_q <= event_d;
		end
	end

	assign edgeSeen = event_q;
endmodule

/* File: hdl/wide_timer_host_access.sv */
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Count, compares and capture are 16-bit, reached as two byte accesses
// - One shared 8-bit staging byte serves every 16-bit register
// - Low-byte write loads staging byte and written low byte together
// - Count or capture low-byte read copies the register high byte into staging
// - Compare high bytes read directly, never through staging
// - BOTTOM is count 0x0000
// - MAX is count 0xFFFF
// - TOP is the sequence peak: MAX, a fixed value, compare A or capture per mode
// - Some modes take TOP from compare A, capture or fixed values
// - Compare A as PWM TOP gives no A output and is double buffered; capture as TOP is not buffered
// - Tick from prescaler or external pin edge; no source stops count
// - Both compare values continuously compared; drive output pins
// - Compare match sets its flag, which can request an interrupt
// - Filtered pin or comparator edge copies count into capture
// - Capture path has a noise-cancelling filter
// - Four flags: overflow, compare A/B, capture; each masked separately
// - Control registers are plain 8-bit, no ordering restriction
// - Count high-byte location reaches the staging byte
// - Host count write beats clear or count in same cycle
// - Each tick clears, increments or decrements per mode
module wide_timer_host_access
	import wide_timer_pkg::*;
#(
	parameter int FILTER_LEN = 4
)
(
	// Clock and reset
	input  logic              mclk,
	input  logic              reset,
	// AXI4-Lite write channels
	input  logic [ADDR_W-1:0] awaddr,
	input  logic              awvalid,
	output logic              awready,
	input  logic [31:0]       wdata,
	input  logic [3:0]        wstrb,
	input  logic              wvalid,
	output logic              wready,
	output logic [1:0]        bresp,
	output logic              bvalid,
	input  logic              bready,
	// AXI4-Lite read channels
	input  logic [ADDR_W-1:0] araddr,
	input  logic              arvalid,
	output logic              arready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	output logic              rvalid,
	input  logic              rready,
	// Timer pins
	input  logic              capturePin,
	input  logic              analogCompOut,
	input  logic              externalCountPin,
	output logic [1:0]        compareOutputPins,
	output logic [3:0]        irqReq
);
	// Bus state
	logic              awHeld_q, awHeld_d, wHeld_q, wHeld_d;
	logic [ADDR_W-1:0] awAddr_q, awAddr_d;
	logic [7:0]        wByte_q, wByte_d;
	logic              wLane_q, wLane_d;
	logic              awready_q, awready_d, wready_q, wready_d;
	logic              bvalid_q, bvalid_d, arready_q, arready_d;
	logic              rvalid_q, rvalid_d;
	logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
	logic [7:0]        rdata_q, rdata_d, rdMux;
	logic              doWrite, doRead, wrEn;
	// Timer state
	logic [7:0]        ctrlA_q, ctrlA_d, ctrlB_q, ctrlB_d;
	logic              srcSel_q, srcSel_d, powerOff_q, powerOff_d;
	logic [3:0]        mask_q, mask_d, flags_q, flags_d;
	logic [7:0]        temp_q, temp_d;
	logic [15:0]       count_q, count_d, capt_q, capt_d;
	logic [15:0]       cmpABuf_q, cmpABuf_d, cmpBBuf_q, cmpBBuf_d;
	logic [15:0]       cmpA_q, cmpA_d, cmpB_q, cmpB_d;
	logic              countUp_q, countUp_d, block_q, block_d;
	logic [1:0]        ocOut_q, ocOut_d;
	logic [3:0]        irqReq_q, irqReq_d;
	// Decoded mode and events
	// Plain vectors: the mode table fills them by one packed concatenation
	logic [1:0]        seq;
	logic [1:0]        topSrc;
	logic [15:0]       topVal;
	logic              pwmMode, tick, captEvent, wrap, ovfSet;
	logic [1:0]        matchHit, forceStrobe;
	logic [3:0]        wave;

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		case (a)
			OFF_CTRL_A, OFF_CTRL_B, OFF_CTRL_C, OFF_COUNT_L,
			OFF_COUNT_H, OFF_CMPA_L, OFF_CMPA_H, OFF_CMPB_L,
			OFF_CMPB_H, OFF_CAPT_L, OFF_CAPT_H, OFF_MASK,
			OFF_FLAG, OFF_POWER: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	// Tick source; power-off holds it quiet
	timer_tick_gen uTick (
		.mclk     (mclk),
		.reset    (reset),
		.clockSel (ctrlB_q[CS_LSB+:3]),
		.powerOff (powerOff_q),
		.extPin   (externalCountPin),
		.tick     (tick)
	);

	// Filtered edge detector on the chosen capture source
	capture_filter #(.FILTER_LEN(FILTER_LEN)) uCapt (
		.mclk      (mclk),
		.reset     (reset),
		.sampleIn  (srcSel_q ? analogCompOut : capturePin),
		.filterOn  (ctrlB_q[NOISE_BIT]),
		.risingSel (ctrlB_q[EDGE_BIT]),
		.edgeSeen  (captEvent)
	);

	// AXI4-Lite slave: address and data taken in either order
	always_comb
	begin
		doWrite = awHeld_q && wHeld_q && !bvalid_q;
		doRead = arvalid && arready_q;
		wrEn = doWrite && wLane_q;
		awHeld_d = awHeld_q;
		wHeld_d = wHeld_q;
		awAddr_d = awAddr_q;
		wByte_d = wByte_q;
		wLane_d = wLane_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (awvalid && awready_q)
		begin
			awHeld_d = 1'b1;
			awAddr_d = awaddr;
		end
		if (wvalid && wready_q)
		begin
			wHeld_d = 1'b1;
			wByte_d = wdata[7:0];
			wLane_d = wstrb[0]; // Only lane 0 carries data
		end
		if (doWrite)
		begin
			awHeld_d = 1'b0;
			wHeld_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = mapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bvalid_q && bready)
			bvalid_d = 1'b0;
		if (doRead)
		begin
			rvalid_d = 1'b1;
			rdata_d = rdMux;
			rresp_d = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_q && rready)
			rvalid_d = 1'b0;
		awready_d = !awHeld_d;
		wready_d = !wHeld_d;
		arready_d = !rvalid_d;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= '0;
			wByte_q <= 8'h00;
			wLane_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 8'h00;
		end
		else
		begin
			awHeld_q <= awHeld_d;
			wHeld_q <= wHeld_d;
			awAddr_q <= awAddr_d;
			wByte_q <= wByte_d;
			wLane_q <= wLane_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	// Read mux; high bytes of count and capture come from staging
	always_comb
	begin
		case (araddr)
			OFF_CTRL_A:  rdMux = ctrlA_q;
			OFF_CTRL_B:  rdMux = ctrlB_q;
			OFF_CTRL_C:  rdMux = {7'h00, srcSel_q}; // Force bits read 0
			OFF_COUNT_L: rdMux = count_q[7:0];
			OFF_COUNT_H: rdMux = temp_q;
			OFF_CMPA_L:  rdMux = cmpABuf_q[7:0];
			OFF_CMPA_H:  rdMux = cmpABuf_q[15:8];
			OFF_CMPB_L:  rdMux = cmpBBuf_q[7:0];
			OFF_CMPB_H:  rdMux = cmpBBuf_q[15:8];
			OFF_CAPT_L:  rdMux = capt_q[7:0];
			OFF_CAPT_H:  rdMux = temp_q;
			OFF_MASK:    rdMux = {4'h0, mask_q};
			OFF_FLAG:    rdMux = {4'h0, flags_q};
			OFF_POWER:   rdMux = {7'h00, powerOff_q};
			default:     rdMux = 8'h00;
		endcase
	end

	// Mode decode: sequence kind and TOP source
	always_comb
	begin
		case ({ctrlB_q[WGMHI_LSB+:2], ctrlA_q[WGMLO_LSB+:2]})
			4'h1: {seq, topSrc, topVal} = {SEQ_PHASE, TOPSRC_FIXED, FIXED_TOP_8};
			4'h2: {seq, topSrc, topVal} = {SEQ_PHASE, TOPSRC_FIXED, FIXED_TOP_9};
			4'h3: {seq, topSrc, topVal} = {SEQ_PHASE, TOPSRC_FIXED, FIXED_TOP_A};
			4'h4: {seq, topSrc, topVal} = {SEQ_CTC, TOPSRC_CMPA, cmpA_q};
			4'h5: {seq, topSrc, topVal} = {SEQ_FAST, TOPSRC_FIXED, FIXED_TOP_8};
			4'h6: {seq, topSrc, topVal} = {SEQ_FAST, TOPSRC_FIXED, FIXED_TOP_9};
			4'h7: {seq, topSrc, topVal} = {SEQ_FAST, TOPSRC_FIXED, FIXED_TOP_A};
			4'h8, 4'hA: {seq, topSrc, topVal} = {SEQ_PHASE, TOPSRC_CAPT, capt_q};
			4'h9, 4'hB: {seq, topSrc, topVal} = {SEQ_PHASE, TOPSRC_CMPA, cmpA_q};
			4'hC: {seq, topSrc, topVal} = {SEQ_CTC, TOPSRC_CAPT, capt_q};
			4'hE: {seq, topSrc, topVal} = {SEQ_FAST, TOPSRC_CAPT, capt_q};
			4'hF: {seq, topSrc, topVal} = {SEQ_FAST, TOPSRC_CMPA, cmpA_q};
			default: {seq, topSrc, topVal} = {SEQ_NORMAL, TOPSRC_FIXED, MAX_VAL};
		endcase
		pwmMode = (seq == SEQ_FAST) || (seq == SEQ_PHASE);
	end

	// Per-channel compare and waveform
	for (genvar ch = 0; ch < 2; ch++)
	begin : gWave
		logic [15:0] cmpVal;
		logic [1:0]  com;
		logic        hold;
		assign cmpVal = (ch == 0) ? cmpA_q : cmpB_q;
		assign com = ctrlA_q[(ch == 0 ? COMA_LSB : COMB_LSB)+:2];
		assign hold = (ch == 0) && pwmMode && (topSrc == TOPSRC_CMPA);
		// Match is blocked on the tick after a host count write
		assign matchHit[ch] = tick && !block_q && (count_q == cmpVal);
		always_comb
		begin
			ocOut_d[ch] = ocOut_q[ch];
			if (com == 2'b00 || hold)
				ocOut_d[ch] = ocOut_q[ch];
			else if (!pwmMode)
			begin
				if (matchHit[ch] || forceStrobe[ch])
					case (com)
						2'b01: ocOut_d[ch] = ~ocOut_q[ch];
						2'b10: ocOut_d[ch] = 1'b0;
						default: ocOut_d[ch] = 1'b1;
					endcase
			end
			else if (seq == SEQ_FAST)
			begin
				if (tick && wrap)
					ocOut_d[ch] = (com == 2'b10);
				else if (matchHit[ch])
					ocOut_d[ch] = (com != 2'b10);
			end
			else if (matchHit[ch])
				ocOut_d[ch] = countUp_q ? (com != 2'b10) : (com == 2'b10);
		end
	end

	// Counter, staging byte, compares, capture and flags
	always_comb
	begin
		count_d = count_q;
		countUp_d = countUp_q;
		temp_d = temp_q;
		cmpABuf_d = cmpABuf_q;
		cmpBBuf_d = cmpBBuf_q;
		cmpA_d = cmpA_q;
		cmpB_d = cmpB_q;
		capt_d = capt_q;
		ctrlA_d = ctrlA_q;
		ctrlB_d = ctrlB_q;
		srcSel_d = srcSel_q;
		powerOff_d = powerOff_q;
		mask_d = mask_q;
		block_d = tick ? 1'b0 : block_q;
		forceStrobe = 2'b00;
		ovfSet = 1'b0;
		wrap = (count_q >= topVal);
		wave = 4'h0;
		if (tick)
			case (seq)
				SEQ_CTC:
				begin
					count_d = (count_q == topVal) ? BOTTOM_VAL
						: count_q + 16'h0001;
					ovfSet = (count_q == MAX_VAL);
				end
				SEQ_FAST:
				begin
					count_d = wrap ? BOTTOM_VAL : count_q + 16'h0001;
					ovfSet = wrap;
				end
				SEQ_PHASE:
					if (countUp_q && wrap)
					begin
						countUp_d = 1'b0;
						count_d = count_q - 16'h0001;
					end
					else if (!countUp_q && count_q == BOTTOM_VAL)
					begin
						countUp_d = 1'b1;
						count_d = count_q + 16'h0001;
						ovfSet = 1'b1;
					end
					else
						count_d = countUp_q ? count_q + 16'h0001
							: count_q - 16'h0001;
				default:
				begin
					count_d = count_q + 16'h0001;
					ovfSet = (count_q == MAX_VAL);
				end
			endcase
		// Buffered compares take effect at TOP in PWM modes
		if (pwmMode && tick && count_q == topVal)
		begin
			cmpA_d = cmpABuf_q;
			cmpB_d = cmpBBuf_q;
		end
		// Capture unless the capture register is serving as TOP or power is off
		if (captEvent && topSrc != TOPSRC_CAPT && !powerOff_q)
			capt_d = count_q;
		// Low-byte read snapshots the high byte
		if (doRead && araddr == OFF_COUNT_L)
			temp_d = count_q[15:8];
		if (doRead && araddr == OFF_CAPT_L)
			temp_d = capt_q[15:8];
		// Host writes come last so they beat count and capture
		if (wrEn)
			case (awAddr_q)
				OFF_CTRL_A: ctrlA_d = wByte_q;
				OFF_CTRL_B: ctrlB_d = wByte_q;
				OFF_CTRL_C:
				begin
					srcSel_d = wByte_q[SRC_BIT];
					forceStrobe = pwmMode ? 2'b00
						: {wByte_q[FORCEB_BIT], wByte_q[FORCEA_BIT]};
				end
				OFF_COUNT_H, OFF_CMPA_H, OFF_CMPB_H, OFF_CAPT_H:
					temp_d = wByte_q;
				OFF_COUNT_L:
				begin
					count_d = {temp_q, wByte_q};
					block_d = 1'b1;
				end
				OFF_CMPA_L:
				begin
					cmpABuf_d = {temp_q, wByte_q};
					if (!pwmMode)
						cmpA_d = {temp_q, wByte_q};
				end
				OFF_CMPB_L:
				begin
					cmpBBuf_d = {temp_q, wByte_q};
					if (!pwmMode)
						cmpB_d = {temp_q, wByte_q};
				end
				OFF_CAPT_L: capt_d = {temp_q, wByte_q};
				OFF_MASK:   mask_d = wByte_q[3:0];
				OFF_POWER:  powerOff_d = wByte_q[0];
				default:    wave = 4'h0;
			endcase
		// Set wins over a write-one clear in the same cycle
		wave[FLG_OVF] = ovfSet;
		wave[FLG_CMPA] = matchHit[0];
		wave[FLG_CMPB] = matchHit[1];
		wave[FLG_CAPT] = captEvent && topSrc != TOPSRC_CAPT && !powerOff_q;
		flags_d = flags_q;
		if (wrEn && awAddr_q == OFF_FLAG)
			flags_d = flags_q & ~wByte_q[3:0];
		flags_d = flags_d | wave;
		irqReq_d = flags_q & mask_q;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			ctrlA_q <= CTRL_RST;
			ctrlB_q <= CTRL_RST;
			srcSel_q <= 1'b0;
			powerOff_q <= 1'b0;
			mask_q <= 4'h0;
			flags_q <= 4'h0;
			temp_q <= 8'h00;
			count_q <= BOTTOM_VAL;
			capt_q <= BOTTOM_VAL;
			cmpABuf_q <= BOTTOM_VAL;
			cmpBBuf_q <= BOTTOM_VAL;
			cmpA_q <= BOTTOM_VAL;
			cmpB_q <= BOTTOM_VAL;
			countUp_q <= 1'b1;
			block_q <= 1'b0;
			ocOut_q <= 2'b00;
			irqReq_q <= 4'h0;
		end
		else
		begin
			ctrlA_q <= ctrlA_d;
			ctrlB_q <= ctrlB_d;
			srcSel_q <= srcSel_d;
			powerOff_q <= powerOff_d;
			mask_q <= mask_d;
			flags_q <= flags_d;
			temp_q <= temp_d;
			count_q <= count_d;
			capt_q <= capt_d;
			cmpABuf_q <= cmpABuf_d;
			cmpBBuf_q <= cmpBBuf_d;
			cmpA_q <= cmpA_d;
			cmpB_q <= cmpB_d;
			countUp_q <= countUp_d;
			block_q <= block_d;
			ocOut_q <= ocOut_d;
			irqReq_q <= irqReq_d;
		end
	end

	// Outputs straight from flops
	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = {24'h000000, rdata_q};
	assign compareOutputPins = ocOut_q;
	assign irqReq = irqReq_q;
endmodule

/* File: tb/wide_timer_host_access_assertions.sv */
`timescale 1ns/1ps
module wide_timer_checker
#(
	parameter int FILTER_LEN = 4
)
(
	// Clock and reset
	input logic        mclk, reset,
	// Bus handshakes and answers
	input logic        awvalid, awready, wvalid, wready,
	input logic        bvalid, bready, arvalid, arready,
	input logic        rvalid, rready,
	input logic [1:0]  bresp, compareOutputPins,
	input logic [31:0] rdata,
	// Interrupt lines
	input logic [3:0]  irqReq
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	a_aw_busy: assert property (awvalid && awready |=> !awready)
		else $error("write address taken while busy");
	a_w_busy: assert property (wvalid && wready |=> !wready)
		else $error("write data taken while busy");
	a_write_answer: assert property (
		awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write answer late");
	a_bresp_hold: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	a_read_answer: assert property (
		arvalid && arready |-> ##[1:2] rvalid)
		else $error("read answer late");
	a_rdata_hold: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	a_read_block: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	a_byte_lane: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("read data wider than a byte");
	a_quiet_start: assert property ($fell(reset) |->
		irqReq == 4'h0 && compareOutputPins == 2'h0)
		else $error("outputs not quiet after reset");

	// Main traffic seen at least once
	c_write: cover property (bvalid && bready);
	c_read: cover property (rvalid && rready);
	c_refused: cover property (bvalid && bresp == 2'h2);
	c_irq: cover property ($rose(irqReq[0]));
endmodule

bind wide_timer_host_access wide_timer_checker #(.FILTER_LEN(FILTER_LEN))
	chk_u (.mclk, .reset, .awvalid, .awready, .wvalid, .wready, .bvalid,
	.bready, .arvalid, .arready, .rvalid, .rready, .bresp,
	.compareOutputPins, .rdata, .irqReq);

/* File: tb/host_core_model.sv */
`timescale 1ns/1ps
module host_core_model
	import wide_timer_pkg::*;
(
	// Clock
	input  logic              mclk,
	// Write side
	output logic [ADDR_W-1:0] awaddr,
	output logic              awvalid, wvalid, bready,
	output logic [31:0]       wdata,
	output logic [3:0]        wstrb,
	input  logic              awready, wready, bvalid,
	input  logic [1:0]        bresp,
	// Read side
	output logic [ADDR_W-1:0] araddr,
	output logic              arvalid, rready,
	input  logic              arready, rvalid,
	input  logic [31:0]       rdata,
	input  logic [1:0]        rresp
);
	// Idle bus from time zero
	initial
	begin
		{awaddr, awvalid, wvalid, bready, wdata} = '0;
		{araddr, arvalid, rready} = '0;
		wstrb = 4'h1;
	end

	// One byte access at a time, in caller order
	task automatic acc(input logic w, input logic [5:0] a,
		input logic [7:0] d, output logic [31:0] q, output logic [1:0] r);
		@(posedge mclk);
		awaddr <= a;
		araddr <= a;
		wdata <= {24'h0, d};
		{awvalid, wvalid, bready} <= {3{w}};
		{arvalid, rready} <= {2{!w}};
		// Each channel let go only at its own handshake
		do
		begin
			@(posedge mclk);
			awvalid <= awvalid & ~awready;
			wvalid <= wvalid & ~wready;
			arvalid <= arvalid & ~arready;
		end
		while (!(bvalid && bready) && !(rvalid && rready));
		q = rdata;
		r = w ? bresp : rresp;
		{bready, rready} <= 2'b00;
		// Stale payload must not look valid
		awaddr <= ~a;
		araddr <= ~a;
		wdata <= ~{24'h0, d};
	endtask
endmodule

/* File: tb/test_wide_timer_host_access.sv */
`timescale 1ns/1ps
module test_wide_timer_host_access
	import wide_timer_pkg::*;
;
	// Bench signals and model state
	logic              mclk, reset;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata;
	logic [3:0]        wstrb, irqReq;
	logic [1:0]        bresp, rresp, compareOutputPins;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic              capturePin, analogCompOut, externalCountPin;
	logic [7:0]        mem [64];
	logic [7:0]        stage, lf;
	logic [5:0]        wl [3];
	logic [2:0]        ec [2];
	int                errorCnt, testsRun, v;

	wide_timer_host_access #(.FILTER_LEN(4)) dut_u (
		.mclk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .capturePin,
		.analogCompOut, .externalCountPin, .compareOutputPins, .irqReq);
	host_core_model host_u (
		.mclk, .awaddr, .awvalid, .wvalid, .bready, .wdata, .wstrb,
		.awready, .wready, .bvalid, .bresp, .araddr, .arvalid, .rready,
		.arready, .rvalid, .rdata, .rresp);

	// 50 ns clock
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	function automatic logic [7:0] nx(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	task automatic chk(input string n, input logic [31:0] e, g);
		testsRun++;
		if (g !== e)
		begin
			errorCnt++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask

	// Write through the host; model keeps staging byte apart
	task automatic wreg(input logic [5:0] a, input logic [7:0] d8);
		logic [31:0] q;
		logic [1:0]  rr, e2;
		logic        wide;
		host_u.acc(1'b1, a, d8, q, rr);
		e2 = (a > OFF_POWER) ? RESP_SLVERR : RESP_OKAY;
		chk("bresp", {30'h0, e2}, {30'h0, rr});
		wide = (a >= OFF_COUNT_L) && (a <= OFF_CAPT_H);
		if (wide && !a[2])
			stage = d8;
		else if (wide)
			{mem[a + 6'h04], mem[a]} = {stage, d8};
		else
			mem[a] = d8;
	endtask

	// Read through the host against the model
	task automatic rchk(input logic [5:0] a);
		logic [7:0]  e;
		logic [31:0] q;
		logic [1:0]  rr, e2;
		e = (a > OFF_POWER) ? 8'h00 : mem[a];
		e2 = (a > OFF_POWER) ? RESP_SLVERR : RESP_OKAY;
		if (a == OFF_COUNT_L || a == OFF_CAPT_L)
			stage = mem[a + 6'h04];
		if (a == OFF_COUNT_H || a == OFF_CAPT_H)
			e = stage;
		host_u.acc(1'b0, a, 8'h00, q, rr);
		chk("rdata", {24'h0, e}, q);
		chk("rresp", {30'h0, e2}, {30'h0, rr});
	endtask

	task automatic rdm(input logic [7:0] m, e);
		logic [31:0] q;
		logic [1:0]  rr;
		host_u.acc(1'b0, OFF_FLAG, 8'h00, q, rr);
		chk("flags", {24'h0, e}, q & {24'h0, m});
	endtask

	task automatic pin_pulse(input int n);
		@(posedge mclk);
		capturePin <= 1'b1;
		repeat (n) @(posedge mclk);
		capturePin <= 1'b0;
		repeat (8) @(posedge mclk);
	endtask

	task automatic finalReport;
		if (errorCnt == 0 && testsRun > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles needed
	initial
	begin
		repeat (20000) @(posedge mclk);
		errorCnt++;
		finalReport();
	end

	initial
	begin
		{reset, capturePin, analogCompOut, externalCountPin} = 4'h8;
		{errorCnt, testsRun, stage, lf} = {32'h0, 32'h0, 8'h00, 8'h5E};
		foreach (mem[i]) mem[i] = 8'h00;
		wl = '{OFF_COUNT_L, OFF_CMPA_L, OFF_CMPB_L};
		ec = '{CS_EXTF, CS_EXTR};
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		// Reset values, then random plain control bytes
		rchk(OFF_CTRL_B);
		rchk(OFF_CAPT_L);
		repeat (4)
		begin
			lf = nx(lf);
			wreg(OFF_CTRL_A, lf);
			rchk(OFF_CTRL_A);
		end
		wreg(OFF_CTRL_A, CTRL_RST);
		// High byte parks in staging until the low byte lands
		foreach (wl[i])
		begin
			lf = nx(lf);
			wreg(wl[i] + 6'h04, lf);
			rchk(wl[i] + 6'h04);
			lf = nx(lf);
			wreg(wl[i], lf);
			rchk(wl[i]);
			rchk(wl[i] + 6'h04);
		end
		wreg(OFF_COUNT_H, 8'hA5);
		wreg(OFF_CMPB_L, 8'h3C);
		rchk(OFF_CMPB_H);
		wreg(6'h38, 8'h5A);
		rchk(6'h3C);
		// Three pin edges of each sense, counter stopped between
		foreach (ec[i])
		begin
			wreg(OFF_CTRL_B, {5'h00, ec[i]});
			repeat (3)
			begin
				@(posedge mclk);
				externalCountPin <= 1'b1;
				repeat (4) @(posedge mclk);
				externalCountPin <= 1'b0;
				repeat (4) @(posedge mclk);
			end
			wreg(OFF_CTRL_B, CTRL_RST);
		end
		v = {mem[OFF_COUNT_H], mem[OFF_COUNT_L]} + 6;
		{mem[OFF_COUNT_H], mem[OFF_COUNT_L]} = v[15:0];
		rchk(OFF_COUNT_L);
		rchk(OFF_COUNT_H);
		// Power-off holds the count with a clock selected
		wreg(OFF_POWER, 8'h01);
		wreg(OFF_CTRL_B, {5'h00, CS_DIV1});
		repeat (20) @(posedge mclk);
		wreg(OFF_CTRL_B, CTRL_RST);
		wreg(OFF_POWER, 8'h00);
		rchk(OFF_COUNT_L);
		rchk(OFF_COUNT_H);
		// Rising capture edge stamps the stopped count
		wreg(OFF_FLAG, 8'h0F);
		wreg(OFF_CTRL_B, 8'h40);
		pin_pulse(6);
		mem[OFF_CAPT_L] = mem[OFF_COUNT_L];
		mem[OFF_CAPT_H] = mem[OFF_COUNT_H];
		rchk(OFF_CAPT_L);
		rchk(OFF_CAPT_H);
		rdm(8'h08, 8'h08);
		// Filter drops a spike but passes a steady level
		wreg(OFF_FLAG, 8'h0F);
		wreg(OFF_CTRL_B, 8'hC0);
		pin_pulse(1);
		rdm(8'h08, 8'h00);
		pin_pulse(8);
		rdm(8'h08, 8'h08);
		// Through MAX with only overflow unmasked
		wreg(OFF_COUNT_H, 8'hFF);
		wreg(OFF_COUNT_L, 8'hF0);
		wreg(OFF_FLAG, 8'h0F);
		wreg(OFF_MASK, 8'h01);
		wreg(OFF_CTRL_B, {5'h00, CS_DIV1});
		repeat (30) @(negedge mclk);
		chk("irqReq", 32'h1, {28'h0, irqReq});
		wreg(OFF_CTRL_B, CTRL_RST);
		rdm(8'h01, 8'h01);
		wreg(OFF_FLAG, 8'h01);
		repeat (3) @(negedge mclk);
		chk("irqReq", 32'h0, {28'h0, irqReq});
		// Comparator output as capture source; the pin is then ignored
		wreg(OFF_FLAG, 8'h0F);
		wreg(OFF_CTRL_C, 8'h01);
		wreg(OFF_CTRL_B, 8'h40);
		pin_pulse(3);
		rdm(8'h08, 8'h00);
		@(posedge mclk);
		analogCompOut <= 1'b1;
		repeat (6) @(posedge mclk);
		rdm(8'h08, 8'h08);
		// Forced compare toggles pin A in a non-PWM mode
		wreg(OFF_CTRL_A, 8'h40);
		wreg(OFF_CTRL_C, 8'h80);
		chk("pins", 32'h1, {30'h0, compareOutputPins});
		finalReport();
	end
endmodule
